// file: aca_pkg.sv
// shared constants, field layout and types of the converter configuration block
package aca_pkg;

  // register addresses on the special-function register bus
  localparam logic [7:0] ACC_CFG_ADDR = 8'hBA;
  localparam logic [7:0] CONV_CFG_ADDR = 8'hBC;
  localparam logic [7:0] RES_LOW_ADDR = 8'hBE;
  localparam logic [7:0] RES_HIGH_ADDR = 8'hBF;

  // values after reset
  localparam logic [7:0] CONV_CFG_RESET = 8'hF8;
  localparam logic [5:0] ACC_CFG_RESET = 6'h00;
  localparam logic [15:0] SUM_RESET = 16'h0000;

  // converter configuration fields
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 3;
  localparam int EIGHT_BIT_POS = 2;
  localparam int TRACK_POS = 1;
  localparam int GAIN_POS = 0;

  // accumulator configuration fields
  localparam int ACC_EN_POS = 6;
  localparam int SJ_MSB = 5;
  localparam int SJ_LSB = 3;
  localparam int RPT_MSB = 2;
  localparam int RPT_LSB = 0;

  // shift and justify codes
  localparam logic [2:0] SJ_RIGHT_0 = 3'h0;
  localparam logic [2:0] SJ_RIGHT_1 = 3'h1;
  localparam logic [2:0] SJ_RIGHT_2 = 3'h2;
  localparam logic [2:0] SJ_RIGHT_3 = 3'h3;
  localparam logic [2:0] SJ_LEFT = 3'h4;
  localparam int LEFT_SHIFT = 6;

  // timing in sar clock cycles
  localparam logic [3:0] TRACK_DELAY_SAR = 4'h3;
  localparam logic [3:0] CONV_SAR_10 = 4'hC;
  localparam logic [3:0] EIGHT_BIT_SAVING = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TRACK = 2'h1,
    ST_CONV = 2'h3,
    ST_DONE = 2'h2
  } aca_state_t;

  // conversions per accumulation; reserved codes fall back to one
  function automatic logic [6:0] aca_rpt_count(input logic [2:0] code);
    case (code)
      3'h0: aca_rpt_count = 7'h01;
      3'h1: aca_rpt_count = 7'h04;
      3'h2: aca_rpt_count = 7'h08;
      3'h3: aca_rpt_count = 7'h10;
      3'h4: aca_rpt_count = 7'h20;
      3'h5: aca_rpt_count = 7'h40;
      default: aca_rpt_count = 7'h01;
    endcase
  endfunction

endpackage

// file: aca_sar_div.sv
// sar conversion clock divider producing one tick per divider+1 source ticks
`timescale 1ns/1ps
`default_nettype none
module aca_sar_div #(
  parameter int DIV_W = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic src_tick,
  input wire logic [DIV_W-1:0] div_val,
  // tick out
  output logic sar_tick_ff
);

  logic [DIV_W-1:0] cnt_ff;

  // phase restarts every time run rises, so each conversion starts aligned
  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      cnt_ff <= '0;
      sar_tick_ff <= 1'b0;
    end else begin
      sar_tick_ff <= 1'b0;
      if (src_tick) begin
        if (cnt_ff == div_val) begin
          cnt_ff <= '0;
          sar_tick_ff <= 1'b1;
        end else begin
          cnt_ff <= DIV_W'(cnt_ff + 1'b1);
        end
      end
    end
  end

  a_tick_source: assert property (@(posedge core_clk) disable iff (srst)
    sar_tick_ff |-> $past(src_tick) && $past(cnt_ff) == $past(div_val))
    else $error("sar tick without divider terminal count");

endmodule
`default_nettype wire

// file: aca_top.sv
// converter configuration, conversion sequencing and result accumulator
//
// Summary of operation
// - sar clock is source divided by field+1
// - source is system clock, oscillator in burst
// - bit two selects eight-bit conversions
// - delayed track adds three sar clocks
// - bit zero selects half or unity gain
// - outside burst, accumulate enable chooses latest or running sum
// - accumulate enable and top bit read zero
// - shift field formats result reads
// - repeat field selects one to sixty-four
// - burst start runs all repeat conversions
// - done flag only after repeat conversions
// - eight-bit is shorter, low byte reads zero
`timescale 1ns/1ps
`default_nettype none
module aca_top #(
  parameter int DIV_W = 5,
  parameter int RES_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_ff,
  // converter control
  input wire logic burst_select,
  input wire logic conv_start,
  input wire logic lpo_tick,
  // analog front end
  input wire logic [RES_W-1:0] sar_result,
  output logic input_gain_select,
  output logic eight_bit_select,
  output logic sar_conversion_clock,
  // status
  output logic tracking_ff,
  output logic busy_ff,
  output logic conversion_done_flag_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] conv_cfg_ff;
  logic [5:0] acc_cfg_ff;
  logic acc_en_ff;
  logic [15:0] sum_ff;
  logic [15:0] fmt_val;
  logic [7:0] nxt_rdata;
  logic wr_conv_cfg;
  logic wr_acc_cfg;
  logic [2:0] sj_code;
  logic [2:0] rpt_code;

  assign wr_conv_cfg = sfr_wr && (sfr_addr == aca_pkg::CONV_CFG_ADDR);
  assign wr_acc_cfg = sfr_wr && (sfr_addr == aca_pkg::ACC_CFG_ADDR);
  assign sj_code = acc_cfg_ff[aca_pkg::SJ_MSB:aca_pkg::SJ_LSB];
  assign rpt_code = acc_cfg_ff[aca_pkg::RPT_MSB:aca_pkg::RPT_LSB];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      conv_cfg_ff <= aca_pkg::CONV_CFG_RESET;
    end else if (wr_conv_cfg) begin
      conv_cfg_ff <= sfr_wdata;
    end
  end

  // the reserved top bit is not stored at all, so it cannot read back
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_cfg_ff <= aca_pkg::ACC_CFG_RESET;
      acc_en_ff <= 1'b0;
    end else if (wr_acc_cfg) begin
      acc_cfg_ff <= sfr_wdata[5:0];
      acc_en_ff <= sfr_wdata[aca_pkg::ACC_EN_POS];
    end
  end

  assign input_gain_select = conv_cfg_ff[aca_pkg::GAIN_POS];
  assign eight_bit_select = conv_cfg_ff[aca_pkg::EIGHT_BIT_POS];

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // formatting is applied here only, the stored sum stays untouched
  always_comb begin
    case (sj_code)
      aca_pkg::SJ_RIGHT_0: fmt_val = sum_ff;
      aca_pkg::SJ_RIGHT_1: fmt_val = sum_ff >> 1;
      aca_pkg::SJ_RIGHT_2: fmt_val = sum_ff >> 2;
      aca_pkg::SJ_RIGHT_3: fmt_val = sum_ff >> 3;
      aca_pkg::SJ_LEFT: fmt_val = sum_ff << aca_pkg::LEFT_SHIFT;
      default: fmt_val = sum_ff;
    endcase
  end

  always_comb begin
    case (sfr_addr)
      aca_pkg::CONV_CFG_ADDR: nxt_rdata = conv_cfg_ff;
      aca_pkg::ACC_CFG_ADDR: nxt_rdata = {2'h0, acc_cfg_ff};
      // eight-bit mode: the high byte carries the eight converted msbs
      aca_pkg::RES_HIGH_ADDR: nxt_rdata = eight_bit_select ? fmt_val[9:2] : fmt_val[15:8];
      aca_pkg::RES_LOW_ADDR: nxt_rdata = eight_bit_select ? 8'h00 : fmt_val[7:0];
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sfr_rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  aca_pkg::aca_state_t state_ff;
  aca_pkg::aca_state_t nxt_state;
  logic [3:0] sar_cnt_ff;
  logic [6:0] conv_num_ff;
  logic [6:0] target;
  logic [6:0] conv_num_inc;
  logic [3:0] conv_len;
  logic last_conv;
  logic src_tick;
  logic sar_tick;
  logic delayed_track;
  logic [15:0] sample;
  logic restart;
  logic div_run;

  assign src_tick = burst_select ? lpo_tick : 1'b1;
  assign delayed_track = conv_cfg_ff[aca_pkg::TRACK_POS];
  assign target = aca_pkg::aca_rpt_count(rpt_code);
  assign conv_num_inc = 7'(conv_num_ff + 7'h01);
  assign last_conv = (conv_num_inc == target);
  assign restart = burst_select && !last_conv;
  assign conv_len = eight_bit_select ? 4'(aca_pkg::CONV_SAR_10 - aca_pkg::EIGHT_BIT_SAVING)
                                     : aca_pkg::CONV_SAR_10;
  assign sample = eight_bit_select ? {6'h00, sar_result[9:2], 2'h0}
                                   : {6'h00, sar_result};
  assign sar_conversion_clock = sar_tick;
  // the divider stops on the edge that takes the last tick, so no stray sar clock leaks out
  assign div_run = (state_ff == aca_pkg::ST_TRACK || state_ff == aca_pkg::ST_CONV)
                   && nxt_state != aca_pkg::ST_DONE;

  aca_sar_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .core_clk(core_clk),
    .srst(srst),
    .run(div_run),
    .src_tick(src_tick),
    .div_val(conv_cfg_ff[aca_pkg::DIV_MSB:aca_pkg::DIV_LSB]),
    .sar_tick_ff(sar_tick)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      aca_pkg::ST_IDLE: begin
        // starts are ignored while a conversion or burst is under way
        if (conv_start) begin
          nxt_state = delayed_track ? aca_pkg::ST_TRACK : aca_pkg::ST_CONV;
        end
      end
      aca_pkg::ST_TRACK: begin
        if (sar_tick && sar_cnt_ff == 4'h1) begin
          nxt_state = aca_pkg::ST_CONV;
        end
      end
      aca_pkg::ST_CONV: begin
        if (sar_tick && sar_cnt_ff == 4'h1) begin
          nxt_state = aca_pkg::ST_DONE;
        end
      end
      aca_pkg::ST_DONE: begin
        if (restart) begin
          nxt_state = delayed_track ? aca_pkg::ST_TRACK : aca_pkg::ST_CONV;
        end else begin
          nxt_state = aca_pkg::ST_IDLE;
        end
      end
      default: nxt_state = aca_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= aca_pkg::ST_IDLE;
      tracking_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tracking_ff <= (nxt_state == aca_pkg::ST_TRACK);
      busy_ff <= (nxt_state != aca_pkg::ST_IDLE);
    end
  end

  // sar cycle counter, loaded on entry to track or convert
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sar_cnt_ff <= 4'h0;
    end else if (nxt_state == aca_pkg::ST_TRACK && state_ff != aca_pkg::ST_TRACK) begin
      sar_cnt_ff <= aca_pkg::TRACK_DELAY_SAR;
    end else if (nxt_state == aca_pkg::ST_CONV && state_ff != aca_pkg::ST_CONV) begin
      sar_cnt_ff <= conv_len;
    end else if (sar_tick && sar_cnt_ff != 4'h0) begin
      sar_cnt_ff <= 4'(sar_cnt_ff - 4'h1);
    end
  end

  // conversions counted toward the repeat target in both modes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      conv_num_ff <= 7'h00;
      conversion_done_flag_ff <= 1'b0;
    end else begin
      conversion_done_flag_ff <= 1'b0;
      if (state_ff == aca_pkg::ST_DONE) begin
        if (last_conv) begin
          conv_num_ff <= 7'h00;
          conversion_done_flag_ff <= 1'b1;
        end else begin
          conv_num_ff <= conv_num_inc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  logic fresh_sum;

  // a burst always begins from zero; outside burst the enable decides
  assign fresh_sum = burst_select ? (conv_num_ff == 7'h00) : !acc_en_ff;

  // a finishing conversion wins over a software byte write in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sum_ff <= aca_pkg::SUM_RESET;
    end else if (state_ff == aca_pkg::ST_DONE) begin
      sum_ff <= fresh_sum ? sample : 16'(sum_ff + sample);
    end else if (sfr_wr && sfr_addr == aca_pkg::RES_HIGH_ADDR) begin
      sum_ff[15:8] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == aca_pkg::RES_LOW_ADDR) begin
      sum_ff[7:0] <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_start_normal: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_IDLE && conv_start && !delayed_track |=> state_ff == aca_pkg::ST_CONV)
    else $error("normal track start did not convert at once");

  a_track_three: assert property (@(posedge core_clk) disable iff (srst)
    $rose(state_ff == aca_pkg::ST_TRACK) |-> sar_cnt_ff == aca_pkg::TRACK_DELAY_SAR)
    else $error("delayed track did not load three sar clocks");

  a_track_hold: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_TRACK && !(sar_tick && sar_cnt_ff == 4'h1)
      |=> state_ff == aca_pkg::ST_TRACK)
    else $error("delayed track left before its last sar clock");

  a_conv_length: assert property (@(posedge core_clk) disable iff (srst)
    $rose(state_ff == aca_pkg::ST_CONV) |-> sar_cnt_ff == (eight_bit_select ? 4'hA : 4'hC))
    else $error("conversion length wrong for resolution");

  a_latest_only: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_DONE && !burst_select && !acc_en_ff |=> sum_ff == $past(sample))
    else $error("latest result not stored");

  a_running_sum: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_DONE && !burst_select && acc_en_ff
      |=> sum_ff == 16'($past(sum_ff) + $past(sample)))
    else $error("accumulated sum wrong");

  a_acc_readback: assert property (@(posedge core_clk) disable iff (srst)
    sfr_rd && sfr_addr == aca_pkg::ACC_CFG_ADDR |=> sfr_rdata_ff[7:6] == 2'h0)
    else $error("write-only or reserved bit read nonzero");

  a_low_zero: assert property (@(posedge core_clk) disable iff (srst)
    sfr_rd && sfr_addr == aca_pkg::RES_LOW_ADDR && eight_bit_select |=> sfr_rdata_ff == 8'h00)
    else $error("low byte nonzero in eight-bit mode");

  a_shift_one: assert property (@(posedge core_clk) disable iff (srst)
    sfr_rd && sfr_addr == aca_pkg::RES_LOW_ADDR && !eight_bit_select && sj_code == 3'h1
      |=> sfr_rdata_ff == $past(sum_ff[8:1]))
    else $error("shift by one formatted wrongly");

  a_sum_kept: assert property (@(posedge core_clk) disable iff (srst)
    wr_acc_cfg && state_ff != aca_pkg::ST_DONE |=> sum_ff == $past(sum_ff))
    else $error("format change altered the stored sum");

  a_done_count: assert property (@(posedge core_clk) disable iff (srst)
    conversion_done_flag_ff |-> $past(conv_num_ff) == 7'($past(target) - 7'h01))
    else $error("done flag before repeat count reached");

  a_burst_continue: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_DONE && burst_select && !last_conv
      |=> state_ff != aca_pkg::ST_IDLE && !conversion_done_flag_ff)
    else $error("burst stopped early");

  a_lpo_source: assert property (@(posedge core_clk) disable iff (srst)
    sar_tick && $past(burst_select) |-> $past(lpo_tick))
    else $error("sar clock ran from system clock in burst mode");

  a_clock_quiet: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_IDLE || state_ff == aca_pkg::ST_DONE |-> !sar_tick)
    else $error("sar clock ran outside track and convert");

  c_burst_four: cover property (@(posedge core_clk) disable iff (srst)
    conversion_done_flag_ff && burst_select && rpt_code == 3'h1);
  c_delayed: cover property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_TRACK ##1 state_ff == aca_pkg::ST_CONV);
  c_accumulate: cover property (@(posedge core_clk) disable iff (srst)
    state_ff == aca_pkg::ST_DONE && acc_en_ff && !burst_select && sum_ff != 16'h0000);
  c_left_read: cover property (@(posedge core_clk) disable iff (srst)
    sfr_rd && sfr_addr == aca_pkg::RES_HIGH_ADDR && sj_code == aca_pkg::SJ_LEFT);

endmodule
`default_nettype wire

// file: testbench.sv
// self-checking testbench for the converter configuration and accumulator block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk;
  logic srst;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_rdata_ff;
  logic burst_select;
  logic conv_start;
  logic lpo_tick = 1'b0;
  logic [9:0] sar_result;
  logic input_gain_select;
  logic eight_bit_select;
  logic sar_conversion_clock;
  logic tracking_ff;
  logic busy_ff;
  logic conversion_done_flag_ff;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int lpo_cnt = 0;
  logic [7:0] rd_val;
  logic [15:0] sum_val;
  logic [15:0] sj_exp [6];
  int rpt_n [6];

  aca_top uut (
    .core_clk(core_clk),
    .srst(srst),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rdata_ff(sfr_rdata_ff),
    .burst_select(burst_select),
    .conv_start(conv_start),
    .lpo_tick(lpo_tick),
    .sar_result(sar_result),
    .input_gain_select(input_gain_select),
    .eight_bit_select(eight_bit_select),
    .sar_conversion_clock(sar_conversion_clock),
    .tracking_ff(tracking_ff),
    .busy_ff(busy_ff),
    .conversion_done_flag_ff(conversion_done_flag_ff)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // low-power oscillator stand-in: one pulse every 5 system clocks (20 MHz)
  always @(posedge core_clk) begin
    lpo_cnt <= (lpo_cnt == 4) ? 0 : lpo_cnt + 1;
    lpo_tick <= #1 (lpo_cnt == 4);
  end

  // the burst tests need about 8000 cycles; a hang must not stall the run forever
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk) #1;
    sfr_wr = 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk) #1;
    sfr_rd = 1'b0;
    rd_val = sfr_rdata_ff;
  endtask

  task automatic rd_sum();
    rd(aca_pkg::RES_HIGH_ADDR);
    sum_val[15:8] = rd_val;
    rd(aca_pkg::RES_LOW_ADDR);
    sum_val[7:0] = rd_val;
  endtask

  // one start; counts sar ticks, spacing of the first two, track cycles, busy gaps, done pulses
  task automatic run_conv(input int exp_ticks, input int exp_gap, input int exp_trk,
                          input bit poke);
    int ticks;
    int dones;
    int first;
    int gap;
    int trk;
    int gaps;
    int n;
    ticks = 0;
    dones = 0;
    first = -1;
    gap = -1;
    trk = 0;
    gaps = 0;
    @(posedge core_clk) #1;
    conv_start = 1'b1;
    @(posedge core_clk) #1;
    conv_start = 1'b0;
    for (n = 0; n < 6000 && dones == 0; n++) begin
      @(posedge core_clk) #1;
      // a second start while busy must be ignored
      conv_start = poke && (n == 4);
      if (sar_conversion_clock === 1'b1) begin
        if (ticks == 1) gap = n - first;
        if (ticks == 0) first = n;
        ticks++;
      end
      if (tracking_ff === 1'b1) trk++;
      if (conversion_done_flag_ff === 1'b1) dones++;
      else if (busy_ff !== 1'b1) gaps++;
    end
    repeat (3) begin
      @(posedge core_clk) #1;
      if (conversion_done_flag_ff === 1'b1) dones++;
    end
    check("sar ticks", exp_ticks, ticks);
    check("tick spacing", exp_gap, gap);
    check("track cycles", exp_trk, trk);
    check("busy gaps", 16'h0000, gaps);
    check("done pulses", 16'h0001, dones);
    check("busy after done", 16'h0000, {15'h0000, busy_ff});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    burst_select = 1'b0;
    conv_start = 1'b0;
    sar_result = 10'h3FF;
    sj_exp = '{16'h07FE, 16'h03FF, 16'h01FF, 16'h00FF, 16'hFF80, 16'h07FE};
    rpt_n = '{1, 4, 8, 16, 32, 64};
    repeat (6) @(posedge core_clk);
    #1 srst = 1'b0;

    rd(aca_pkg::CONV_CFG_ADDR);
    check("conv cfg reset", 16'h00F8, rd_val);
    rd(aca_pkg::ACC_CFG_ADDR);
    check("acc cfg reset", 16'h0000, rd_val);
    rd_sum();
    check("sum reset", 16'h0000, sum_val);
    rd(8'h55);
    check("unmapped read", 16'h0000, rd_val);
    $display("test reset done");

    wr(aca_pkg::CONV_CFG_ADDR, 8'h05);
    check("gain unity", 16'h0001, input_gain_select);
    check("eight bit on", 16'h0001, eight_bit_select);
    rd(aca_pkg::CONV_CFG_ADDR);
    check("conv cfg rw", 16'h0005, rd_val);
    wr(aca_pkg::CONV_CFG_ADDR, 8'h00);
    check("gain half", 16'h0000, input_gain_select);
    check("eight bit off", 16'h0000, eight_bit_select);
    wr(aca_pkg::ACC_CFG_ADDR, 8'hF8);
    rd(aca_pkg::ACC_CFG_ADDR);
    check("acc cfg readback", 16'h0038, rd_val);
    wr(aca_pkg::ACC_CFG_ADDR, 8'h00);
    $display("test registers done");

    // delayed track: three sar clocks seen as three tracking cycles at divider zero
    run_conv(12, 1, 0, 1'b1);
    wr(aca_pkg::CONV_CFG_ADDR, 8'h10);
    run_conv(12, 3, 0, 1'b0);
    wr(aca_pkg::CONV_CFG_ADDR, 8'h02);
    run_conv(15, 1, 3, 1'b0);
    wr(aca_pkg::CONV_CFG_ADDR, 8'h06);
    run_conv(13, 1, 3, 1'b0);
    wr(aca_pkg::CONV_CFG_ADDR, 8'h04);
    run_conv(10, 1, 0, 1'b0);
    rd_sum();
    check("eight bit result", 16'hFF00, sum_val);
    wr(aca_pkg::CONV_CFG_ADDR, 8'h00);
    run_conv(12, 1, 0, 1'b0);
    rd_sum();
    check("latest result", 16'h03FF, sum_val);
    $display("test timing done");

    wr(aca_pkg::ACC_CFG_ADDR, 8'h40);
    wr(aca_pkg::RES_HIGH_ADDR, 8'h00);
    wr(aca_pkg::RES_LOW_ADDR, 8'h00);
    run_conv(12, 1, 0, 1'b0);
    run_conv(12, 1, 0, 1'b0);
    rd(aca_pkg::ACC_CFG_ADDR);
    check("acc enable reads zero", 16'h0000, rd_val);
    // the last pass uses a reserved code, which must read unshifted
    for (int i = 0; i < 6; i++) begin
      wr(aca_pkg::ACC_CFG_ADDR, {2'b01, 3'(i), 3'b000});
      rd_sum();
      check("formatted sum", sj_exp[i], sum_val);
    end
    $display("test accumulate done");

    burst_select = 1'b1;
    sar_result = 10'h001;
    for (int i = 0; i < 6; i++) begin
      wr(aca_pkg::ACC_CFG_ADDR, {5'b00000, 3'(i)});
      run_conv(12 * rpt_n[i], 5, 0, 1'b0);
      rd_sum();
      check("burst sum", 16'(rpt_n[i]), sum_val);
    end
    burst_select = 1'b0;
    wr(aca_pkg::ACC_CFG_ADDR, 8'h00);
    $display("test burst done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
